// ===== hdl/css_channel.sv
`timescale 1ns/1ps
module css_channel #(
	parameter int FIFO_DEPTH = css_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	// Microprocessor port
	input  wire logic [css_pkg::ADDR_W-1:0]        up_addr,
	input  wire logic                              up_wr,
	input  wire logic                              up_rd,
	input  wire logic [css_pkg::DATA_W-1:0]        up_wdata,
	output logic [css_pkg::DATA_W-1:0]             up_rdata,
	input  wire logic                              top_status_wr,
	output logic                                   top_status,
	// Serial link
	input  wire logic                              serial_clk,
	input  wire logic                              serial_frame_strobe,
	input  wire logic                              serial_data,
	input  wire logic                              tx_enable,
	output logic                                   serial_data_request,
	// Channel controls
	input  wire logic                              vector_modulation_mode,
	input  wire logic [1:0]                        word_length_code,
	input  wire logic                              online_ctl,
	input  wire logic [css_pkg::RAD_W-1:0]         almost_empty_thr,
	// Filter saturation events
	input  css_pkg::css_sat_type                   filter_sat,
	// Symbol stream to the filters
	output logic                                   sym_valid,
	input  wire logic                              sym_ready,
	output css_pkg::css_sym_type                   sym_data,
	// Indirect RAM
	output css_pkg::css_ram_req_type               ram_req,
	input  wire logic [css_pkg::DATA_W-1:0]        ram_rd_data,
	// Channel state
	output logic                                   channel_online
);
	localparam int CW = $clog2(FIFO_DEPTH+1);

	typedef struct packed {
		logic                           sclk_s1;
		logic                           sclk_s2;
		logic                           sclk_s3;
		logic                           fs_s1;
		logic                           fs_s2;
		logic                           sd_s1;
		logic                           sd_s2;
		logic                           txen_s1;
		logic                           txen_s2;
		logic [css_pkg::SLOT_W-1:0]     islot;
		logic [css_pkg::SLOT_W-1:0]     qslot;
		logic [css_pkg::SLOT_W-1:0]     icnt;
		logic [css_pkg::SLOT_W-1:0]     qcnt;
		logic                           irun;
		logic                           qrun;
		logic [css_pkg::DATA_W-1:0]     shift;
		css_pkg::css_sym_type           sym;
		logic                           i_have;
		logic                           q_have;
		logic                           push;
		css_pkg::css_ram_req_type       ram;
		logic                           rd_pend;
		logic [css_pkg::DATA_W-1:0]     rdata;
		logic [css_pkg::STAT_W-1:0]     status;
		logic                           top;
		logic                           forced_off;
		logic [4:0]                     flush_cnt;
		logic                           flushed;
	} css_ch_st_type;

	css_ch_st_type                  s_q;
	css_ch_st_type                  s_d;
	logic                           fifo_in_ready;
	logic [CW-1:0]                  fifo_level;
	logic [css_pkg::RAD_W-1:0]      rad;
	logic                           sclk_edge;
	logic                           i_carry;
	logic                           q_carry;
	logic [css_pkg::DATA_W-1:0]     word;
	logic                           online;
	logic                           underflow;
	logic [css_pkg::STAT_W-1:0]     stat_now;

	css_fifo #(
		.W     ($bits(css_pkg::css_sym_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (s_q.push),
		.in_ready  (fifo_in_ready),
		.in_data   (s_q.sym),
		.out_valid (sym_valid),
		.out_ready (sym_ready),
		.out_data  (sym_data),
		.level     (fifo_level)
	);

	// Read address view saturates at full; the deeper FIFO only adds slack
	assign rad = (fifo_level >= CW'(css_pkg::RAD_FULL)) ? css_pkg::RAD_FULL : fifo_level[css_pkg::RAD_W-1:0]; // [R14]
	assign sclk_edge = s_q.sclk_s2 & ~s_q.sclk_s3;
	assign online    = online_ctl & ~s_q.forced_off;
	assign i_carry   = sclk_edge & ~s_q.fs_s2 & s_q.irun & (s_q.icnt == s_q.islot); // [R1] [R4]
	assign q_carry   = sclk_edge & ~s_q.fs_s2 & s_q.qrun & (s_q.qcnt == s_q.qslot); // [R2] [R4]
	assign underflow = sym_ready & (rad == css_pkg::RAD_EMPTY) & ~s_q.push; // [R15]
	assign serial_data_request = s_q.txen_s2 & online & fifo_in_ready; // [R24]
	assign channel_online = online;
	assign up_rdata   = s_q.rdata;
	assign top_status = s_q.top;
	assign ram_req    = s_q.ram;

	always_comb
	begin
		stat_now = css_pkg::RST_STATUS;
		stat_now[css_pkg::ST_FLUSHED] = s_q.flushed;
		stat_now[css_pkg::ST_IPOS]    = filter_sat.ipos; // [R12]
		stat_now[css_pkg::ST_QPOS]    = filter_sat.qpos; // [R12]
		stat_now[css_pkg::ST_INEG]    = filter_sat.ineg; // [R13]
		stat_now[css_pkg::ST_QNEG]    = filter_sat.qneg; // [R13]
		stat_now[css_pkg::ST_RAD_LO +: css_pkg::RAD_W] = rad; // [R14]
		stat_now[css_pkg::ST_UNDER]   = underflow;
		stat_now[css_pkg::ST_OVER]    = (rad == css_pkg::RAD_FULL); // [R16]
		stat_now[css_pkg::ST_AEMPTY]  = (rad < almost_empty_thr); // [R17]
		stat_now[css_pkg::ST_EMPTY]   = (rad == css_pkg::RAD_EMPTY); // [R18]
	end

	// Word length keeps the newest bits, low aligned; the bit arriving at the carry edge is included
	always_comb
	begin
		case (word_length_code) // [R23]
			css_pkg::WL_16: word = {s_q.shift[14:0], s_q.sd_s2};
			css_pkg::WL_12: word = {4'h0, s_q.shift[10:0], s_q.sd_s2};
			css_pkg::WL_8:  word = {8'h00, s_q.shift[6:0], s_q.sd_s2};
			css_pkg::WL_4:  word = {12'h000, s_q.shift[2:0], s_q.sd_s2};
			default:        word = {s_q.shift[14:0], s_q.sd_s2};
		endcase
	end

	always_comb
	begin
		s_d = s_q;
		// Pin synchronisers; first stages feed only the second
		s_d.sclk_s1 = serial_clk;
		s_d.sclk_s2 = s_q.sclk_s1;
		s_d.sclk_s3 = s_q.sclk_s2;
		s_d.fs_s1   = serial_frame_strobe;
		s_d.fs_s2   = s_q.fs_s1;
		s_d.sd_s1   = serial_data;
		s_d.sd_s2   = s_q.sd_s1;
		s_d.txen_s1 = tx_enable;
		s_d.txen_s2 = s_q.txen_s1;
		s_d.push    = 1'b0;
		s_d.ram.strobe = 1'b0;
		s_d.rd_pend = 1'b0;

		if (sclk_edge)
		begin
			s_d.shift = {s_q.shift[css_pkg::DATA_W-2:0], s_q.sd_s2};
			if (s_q.fs_s2)
			begin
				s_d.icnt   = css_pkg::RST_SLOT; // [R3]
				s_d.qcnt   = css_pkg::RST_SLOT; // [R3]
				s_d.irun   = 1'b1;
				s_d.qrun   = 1'b1;
				s_d.i_have = 1'b0;
				s_d.q_have = 1'b0;
			end
			else
			begin
				// Stop after carry so a long frame cannot produce a second symbol
				if (i_carry)
					s_d.irun = 1'b0; // [R26]
				else if (s_q.irun)
					s_d.icnt = SLOT_INC(s_q.icnt); // [R1]
				if (q_carry)
					s_d.qrun = 1'b0; // [R26]
				else if (s_q.qrun)
					s_d.qcnt = SLOT_INC(s_q.qcnt); // [R2]
			end
		end

		// Arrival order follows whichever slot value is smaller
		if (i_carry)
		begin
			s_d.sym.i  = word; // [R7]
			s_d.i_have = 1'b1;
		end
		if (q_carry)
		begin
			s_d.sym.q  = word; // [R7]
			s_d.q_have = 1'b1;
		end
		if (!vector_modulation_mode && i_carry)
		begin
			s_d.push   = online; // [R6]
			s_d.i_have = 1'b0;
		end
		else if (vector_modulation_mode && s_d.i_have && s_d.q_have)
		begin
			s_d.push   = online; // [R5]
			s_d.i_have = 1'b0;
			s_d.q_have = 1'b0;
		end

		// Register writes; reserved slot bits are dropped
		if (up_wr)
		begin
			case (up_addr)
				css_pkg::OFS_ISLOT: s_d.islot = up_wdata[css_pkg::SLOT_W-1:0]; // [R27]
				css_pkg::OFS_QSLOT: s_d.qslot = up_wdata[css_pkg::SLOT_W-1:0]; // [R27]
				css_pkg::OFS_RDATA: s_d.ram.data = up_wdata; // [R8]
				css_pkg::OFS_RADDR:
				begin
					s_d.ram.addr   = up_wdata;
					s_d.ram.read   = up_wdata[css_pkg::RAM_RD_BIT]; // [R9]
					s_d.ram.strobe = 1'b1; // [R9]
				end
				default: ;
			endcase
		end
		// Read data returns the cycle after the read strobe
		if (s_q.ram.strobe && s_q.ram.read)
			s_d.rd_pend = 1'b1;
		if (s_q.rd_pend)
			s_d.ram.data = ram_rd_data; // [R8]

		if (up_rd)
		begin
			case (up_addr)
				css_pkg::OFS_ISLOT:  s_d.rdata = {6'h00, s_q.islot}; // [R27]
				css_pkg::OFS_QSLOT:  s_d.rdata = {6'h00, s_q.qslot}; // [R27]
				css_pkg::OFS_RDATA:  s_d.rdata = s_q.ram.data;
				css_pkg::OFS_RADDR:  s_d.rdata = s_q.ram.addr;
				css_pkg::OFS_STATUS: s_d.rdata = {4'h0, s_q.status}; // [R27]
				default:             s_d.rdata = css_pkg::RST_WORD;
			endcase
		end

		// Off-line forcing holds until software drops the on-line bit
		if (rad == css_pkg::RAD_FULL)
			s_d.forced_off = 1'b1; // [R22]
		else if (!online_ctl)
			s_d.forced_off = 1'b0;

		// Flush counts reads made once off-line; reads run every sample clock
		if (online)
		begin
			s_d.flush_cnt = 5'h00;
			s_d.flushed   = 1'b0;
		end
		else if (sym_ready && !s_q.flushed)
		begin
			s_d.flush_cnt = 5'(s_q.flush_cnt + 1'b1); // [R10] [R11]
			if (s_d.flush_cnt == css_pkg::FLUSH_READS)
				s_d.flushed = 1'b1; // [R10] [R11]
		end

		// Sticky status; a fresh event wins over the clear
		if (top_status_wr)
			s_d.status = stat_now; // [R21]
		else
			s_d.status = s_q.status | stat_now; // [R20]
		s_d.top = |{s_d.status[css_pkg::ST_IPOS:css_pkg::ST_QNEG], s_d.status[css_pkg::ST_UNDER]}; // [R19]
	end

	function automatic logic [css_pkg::SLOT_W-1:0] SLOT_INC(input logic [css_pkg::SLOT_W-1:0] v);
		SLOT_INC = css_pkg::SLOT_W'(v + 1'b1);
	endfunction

	function automatic logic [css_pkg::DATA_W-1:0] WL_MASK(input logic [1:0] c);
		case (c)
			css_pkg::WL_12: WL_MASK = 16'h0fff;
			css_pkg::WL_8:  WL_MASK = 16'h00ff;
			css_pkg::WL_4:  WL_MASK = 16'h000f;
			default:        WL_MASK = 16'hffff;
		endcase
	endfunction

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_islot_carry_hold: assert property (i_carry |=> !s_q.irun) else $error("in-phase counter kept running"); // [R26]
	a_frame_restart: assert property (sclk_edge && s_q.fs_s2 |=> s_q.irun && s_q.qrun && s_q.icnt == '0)
		else $error("frame strobe did not restart counters"); // [R3]
	a_fm_push_now: assert property (!vector_modulation_mode && i_carry && online |=> s_q.push)
		else $error("fm symbol not pushed"); // [R6]
	a_vector_pair_wait: assert property (vector_modulation_mode && s_q.push |-> $past(s_q.i_have | i_carry) && $past(s_q.q_have | q_carry))
		else $error("vector push without both symbols"); // [R5]
	a_ram_addr_strobe: assert property (up_wr && up_addr == css_pkg::OFS_RADDR |=>
		s_q.ram.strobe && s_q.ram.read == $past(up_wdata[css_pkg::RAM_RD_BIT]))
		else $error("ram access not started"); // [R9]
	a_full_forces_off: assert property (rad == css_pkg::RAD_FULL |=> !online) else $error("overflow left channel on-line"); // [R22]
	a_underflow_latch: assert property (underflow && !top_status_wr |=> s_q.status[css_pkg::ST_UNDER] && s_q.top)
		else $error("underflow not latched"); // [R15]
	a_status_sticky: assert property (s_q.status[css_pkg::ST_IPOS] && !top_status_wr |=> s_q.status[css_pkg::ST_IPOS])
		else $error("status dropped without clear"); // [R21]
	a_flush_count: assert property (!online && s_q.flush_cnt == 5'(css_pkg::FLUSH_READS - 1'b1) && sym_ready &&
		!s_q.flushed |=> s_q.flushed)
		else $error("flush not flagged at 24 reads"); // [R10]
	a_no_early_flush: assert property (s_q.flushed |-> s_q.flush_cnt == css_pkg::FLUSH_READS)
		else $error("flushed before 24 reads"); // [R11]
	a_flush_clear: assert property (online |=> !s_q.flushed) // [R10]
		else $error("flushed flag kept while on-line");

	// Symbol path checks
	a_qslot_carry_hold: assert property (q_carry |=> !s_q.qrun) // [R26]
		else $error("quadrature counter kept running");
	a_offline_no_push: assert property (!online |=> !s_q.push) // [R22]
		else $error("symbol pushed while off-line");
	a_pair_clears: assert property (vector_modulation_mode && s_q.push |-> !s_q.i_have && !s_q.q_have) // [R5]
		else $error("pair flags left after push");
	a_symbol_width: assert property (s_q.push |-> (s_q.sym.i & ~WL_MASK(word_length_code)) == '0) // [R23]
		else $error("symbol wider than word length");
	a_request_gate: assert property (!s_q.txen_s2 |-> !serial_data_request) // [R24]
		else $error("serial request while transmit disabled");

	// Register port checks
	a_ram_data_write: assert property (up_wr && up_addr == css_pkg::OFS_RDATA && !s_q.rd_pend |=>
		s_q.ram.data == $past(up_wdata)) // [R8]
		else $error("ram data register not written");
	a_status_reserved: assert property (up_rd && up_addr == css_pkg::OFS_STATUS |=>
		s_q.rdata[css_pkg::DATA_W-1:css_pkg::STAT_W] == '0) // [R27]
		else $error("status reserved bits not zero");
	a_slot_reserved: assert property (up_rd && (up_addr == css_pkg::OFS_ISLOT || up_addr == css_pkg::OFS_QSLOT) |=>
		s_q.rdata[css_pkg::DATA_W-1:css_pkg::SLOT_W] == '0) // [R27]
		else $error("slot reserved bits not zero");

	// Status view; latched copies lag the live value by one clock
	a_read_addr_view: assert property (fifo_level <= CW'(css_pkg::RAD_FULL) |-> rad == fifo_level[css_pkg::RAD_W-1:0]) // [R14]
		else $error("read address view wrong");
	a_overflow_bit: assert property (rad == css_pkg::RAD_FULL |=> s_q.status[css_pkg::ST_OVER]) // [R16]
		else $error("overflow bit not set");
	a_empty_bit: assert property (!sym_valid |=> s_q.status[css_pkg::ST_EMPTY]) // [R18]
		else $error("empty bit not set");
	a_almost_empty: assert property (rad < almost_empty_thr |=> s_q.status[css_pkg::ST_AEMPTY]) // [R17]
		else $error("almost empty bit not set");
	a_pos_sat_latch: assert property (filter_sat.ipos |=> s_q.status[css_pkg::ST_IPOS] && s_q.top) // [R12] [R19]
		else $error("positive saturation not latched");
	a_neg_sat_latch: assert property (filter_sat.qneg |=> s_q.status[css_pkg::ST_QNEG] && s_q.top) // [R13] [R19]
		else $error("negative saturation not latched");
endmodule

// ===== hdl/css_fifo.sv
`timescale 1ns/1ps
module css_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Fill side
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	// Drain side
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [W-1:0]                    out_data,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wr;
		logic [PW-1:0]           rd;
		logic [CW-1:0]           cnt;
		logic [W-1:0]            head;
	} css_fifo_st_type;

	css_fifo_st_type s_q;
	css_fifo_st_type s_d;
	logic            push;
	logic            pop;
	logic [PW-1:0]   rd_nx;

	assign in_ready  = (s_q.cnt != CW'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.head;
	assign level     = s_q.cnt;

	always_comb
	begin
		s_d   = s_q;
		push  = in_valid & in_ready;
		pop   = out_valid & out_ready;
		rd_nx = pop ? PW'(s_q.rd + 1'b1) : s_q.rd;
		if (push)
		begin
			s_d.mem[s_q.wr] = in_data;
			s_d.wr          = PW'(s_q.wr + 1'b1);
		end
		s_d.rd  = rd_nx;
		s_d.cnt = CW'(s_q.cnt + CW'(push) - CW'(pop));
		// Head comes from a register; bypass covers a write into the slot being read
		s_d.head = (push && s_q.wr == rd_nx) ? in_data : s_q.mem[rd_nx];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

// ===== hdl/css_pkg.sv
// Function
// R1: In-phase 10-bit slot counter at serial rate
// R2: Quadrature 10-bit slot counter at serial rate
// R3: Frame strobe starts both slot counters
// R4: Counter carry marks a complete symbol
// R5: Vector mode pushes pair after both arrive
// R6: FM mode pushes in-phase symbol immediately
// R7: Slot values set in-phase/quadrature order
// R8: Indirect RAM data register at 0x14
// R9: Address write starts access, bit15 read
// R10: Flushed bit after 24 off-line reads
// R11: Flushed 24 sample clocks after off-line
// R12: Bits 10/8 flag positive filter saturation
// R13: Bits 9/7 flag negative filter saturation
// R14: Bits 6:4 give FIFO read address
// R15: Underflow on read at empty without write
// R16: Overflow flag when read address is 7
// R17: Almost empty below programmed threshold
// R18: Empty flag when read address is 0
// R19: Bits 10:7,3 ORed into top status
// R20: All status bits 11:0 latched
// R21: Only top status write clears latched status
// R22: FIFO overflow forces channel off-line
// R23: Word length codes select 16/12/8/4 bits
// R24: Transmit enable gates serial data requests
// R25: Host waits 4 clocks between RAM writes
// R26: Slot counter holds after carry until strobe
// R27: Reserved bits read zero, writes ignored
package css_pkg;

	localparam int DATA_W   = 16;
	localparam int SLOT_W   = 10;
	localparam int ADDR_W   = 8;
	localparam int STAT_W   = 12;
	localparam int RAD_W    = 3;
	localparam int FIFO_DEPTH = 16;

	localparam logic [ADDR_W-1:0] OFS_ISLOT  = 8'h12;
	localparam logic [ADDR_W-1:0] OFS_QSLOT  = 8'h13;
	localparam logic [ADDR_W-1:0] OFS_RDATA  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RADDR  = 8'h15;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h16;

	localparam int RAM_RD_BIT = 15;

	localparam int ST_FLUSHED = 11;
	localparam int ST_IPOS    = 10;
	localparam int ST_INEG    = 9;
	localparam int ST_QPOS    = 8;
	localparam int ST_QNEG    = 7;
	localparam int ST_RAD_LO  = 4;
	localparam int ST_UNDER   = 3;
	localparam int ST_OVER    = 2;
	localparam int ST_AEMPTY  = 1;
	localparam int ST_EMPTY   = 0;

	localparam logic [RAD_W-1:0] RAD_EMPTY = 3'h0;
	localparam logic [RAD_W-1:0] RAD_FULL  = 3'h7;

	localparam logic [4:0] FLUSH_READS = 5'h18;

	localparam logic [1:0] WL_16 = 2'h0;
	localparam logic [1:0] WL_12 = 2'h1;
	localparam logic [1:0] WL_8  = 2'h2;
	localparam logic [1:0] WL_4  = 2'h3;

	localparam logic [STAT_W-1:0] RST_STATUS = 12'h000;
	localparam logic [DATA_W-1:0] RST_WORD   = 16'h0000;
	localparam logic [SLOT_W-1:0] RST_SLOT   = 10'h000;

	typedef struct packed {
		logic [DATA_W-1:0] i;
		logic [DATA_W-1:0] q;
	} css_sym_type;

	typedef struct packed {
		logic              strobe;
		logic              read;
		logic [DATA_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} css_ram_req_type;

	typedef struct packed {
		logic ipos;
		logic ineg;
		logic qpos;
		logic qneg;
	} css_sat_type;

endpackage

// ===== testbench/css_serial_src.sv
`timescale 1ns/1ps
module css_serial_src (
	// Request from the channel
	input  wire logic serial_data_request,
	// Serial link
	output logic      serial_clk,
	output logic      serial_frame_strobe,
	output logic      serial_data
);
	initial
	begin
		serial_clk = 1'b0;
		serial_frame_strobe = 1'b0;
		serial_data = 1'b0;
	end

	// Clock idles low between frames; frames start only on request
	task automatic send(input logic [31:0] frame);
		wait (serial_data_request === 1'b1);
		#13;
		for (int b = 31; b >= 0; b--)
		begin
			serial_data = frame[b];
			serial_frame_strobe = (b == 31); // Strobe on first bit
			#100 serial_clk = 1'b1;
			#100 serial_clk = 1'b0;
		end
		serial_frame_strobe = 1'b0;
		// No stale bit left on the line
		serial_data = ~serial_data;
	endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                     clk = 1'b0;
	logic                     rst_n = 1'b0;
	logic [7:0]               up_addr = 8'h00;
	logic                     up_wr = 1'b0;
	logic                     up_rd = 1'b0;
	logic [15:0]              up_wdata = 16'h0000;
	logic [15:0]              up_rdata;
	logic                     top_status_wr = 1'b0;
	logic                     top_status;
	logic                     serial_clk;
	logic                     serial_frame_strobe;
	logic                     serial_data;
	logic                     tx_enable = 1'b1;
	logic                     serial_data_request;
	logic                     vector_modulation_mode = 1'b1;
	logic [1:0]               word_length_code = 2'h0;
	logic                     online_ctl = 1'b1;
	logic [2:0]               almost_empty_thr = 3'h2;
	css_pkg::css_sat_type     filter_sat = '0;
	logic                     sym_valid;
	logic                     sym_ready = 1'b0;
	css_pkg::css_sym_type     sym_data;
	css_pkg::css_ram_req_type ram_req;
	logic [15:0]              ram_rd_data;
	logic                     channel_online;
	int                       error_cnt = 0;
	int                       n_tests = 0;
	logic [15:0]              iv;
	logic [15:0]              qv;
	int                       n;

	always #12.5 clk = ~clk;
	// RAM answers at once, well inside the one-cycle budget
	assign ram_rd_data = ram_req.addr ^ 16'hc33c;

	css_channel i_dut (.clk(clk), .rst_n(rst_n), .up_addr(up_addr), .up_wr(up_wr), .up_rd(up_rd),
		.up_wdata(up_wdata), .up_rdata(up_rdata), .top_status_wr(top_status_wr), .top_status(top_status),
		.serial_clk(serial_clk), .serial_frame_strobe(serial_frame_strobe), .serial_data(serial_data),
		.tx_enable(tx_enable), .serial_data_request(serial_data_request),
		.vector_modulation_mode(vector_modulation_mode), .word_length_code(word_length_code),
		.online_ctl(online_ctl), .almost_empty_thr(almost_empty_thr), .filter_sat(filter_sat),
		.sym_valid(sym_valid), .sym_ready(sym_ready), .sym_data(sym_data), .ram_req(ram_req),
		.ram_rd_data(ram_rd_data), .channel_online(channel_online));

	css_serial_src i_src (.serial_data_request(serial_data_request), .serial_clk(serial_clk),
		.serial_frame_strobe(serial_frame_strobe), .serial_data(serial_data));

	task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		up_addr <= a;
		up_wdata <= d;
		up_wr <= 1'b1;
		@(posedge clk);
		up_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input string w, input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
		@(posedge clk);
		up_addr <= a;
		up_rd <= 1'b1;
		@(posedge clk);
		up_rd <= 1'b0;
		#1;
		chk(w, {18'h0, e}, {18'h0, up_rdata & m});
	endtask

	task automatic clr();
		@(posedge clk);
		top_status_wr <= 1'b1;
		@(posedge clk);
		top_status_wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic pop(input int k);
		@(posedge clk);
		sym_ready <= 1'b1;
		repeat (k) @(posedge clk);
		sym_ready <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Sync and push latency is a few clocks; twelve leaves margin
	task automatic sendf(input logic [31:0] f);
		i_src.send(f);
		repeat (12) @(posedge clk);
		#1;
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		#400000;
		error_cnt++;
		summarize();
	end

	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd("status_rst", 8'h16, 16'h0003); // Empty, below threshold
		wr(8'h12, 16'hffff);
		rd("islot", 8'h12, 16'h03ff); // Reserved bits zero
		wr(8'h13, 16'hfc00);
		rd("qslot", 8'h13, 16'h0000);
		wr(8'h16, 16'hffff);
		rd("status_ro", 8'h16, 16'h0003); // Write ignored
		rd("unmapped", 8'h20, 16'h0000);
		wr(8'h14, 16'h1234);
		rd("ram_data", 8'h14, 16'h1234);
		wr(8'h15, 16'h0005);
		chk("ram_wr_req", {2'b10, 16'h0005, 16'h1234}, ram_req); // Write access
		@(posedge clk);
		#1;
		chk("ram_strobe", 1'b0, ram_req.strobe);
		repeat (4) @(posedge clk);
		wr(8'h15, 16'h8005);
		chk("ram_rd_req", {2'b11, 16'h8005}, ram_req[33:16]); // Read access
		repeat (3) @(posedge clk);
		rd("ram_rd_data", 8'h14, 16'h4339);
		rd("ram_addr", 8'h15, 16'h8005);
		// Every word length, vector mode pairs
		for (int c = 0; c < 4; c++)
		begin
			n = 16 - 4 * c;
			iv = 16'ha5c3 & (16'hffff >> (16 - n));
			qv = 16'h3c5a & (16'hffff >> (16 - n));
			word_length_code <= 2'(c);
			wr(8'h12, 16'(n - 2));
			wr(8'h13, 16'(2 * n - 2));
			sendf((32'(iv) << (32 - n)) | (32'(qv) << (32 - 2 * n)));
			chk("sym_valid", 1'b1, sym_valid);
			chk("sym_pair", {iv, qv}, sym_data);
			pop(1);
			chk("sym_empty", 1'b0, sym_valid);
		end
		word_length_code <= 2'h0;
		wr(8'h12, 16'h000e);
		wr(8'h13, 16'h03ff);
		sendf({16'h1357, 16'h2468});
		chk("no_pair", 1'b0, sym_valid); // Quadrature never arrived
		vector_modulation_mode <= 1'b0;
		sendf({16'h1357, 16'h2468});
		chk("fm_valid", 1'b1, sym_valid);
		chk("fm_i", 16'h1357, sym_data.i);
		clr();
		rd("one_entry", 8'h16, 16'h0012); // One push per frame
		pop(1);
		vector_modulation_mode <= 1'b1;
		wr(8'h12, 16'h001e);
		wr(8'h13, 16'h000e);
		sendf({16'h9abc, 16'h7531});
		chk("swapped", {16'h7531, 16'h9abc}, sym_data); // Slot order
		pop(1);
		clr();
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			filter_sat <= css_pkg::css_sat_type'(4'(4'h8 >> k));
			@(posedge clk);
			filter_sat <= '0;
			rd("sat", 8'h16, 16'h0400 >> k, 16'h0400 >> k); // Latched
			chk("top_sat", 1'b1, top_status);
			clr();
		end
		rd("after_clr", 8'h16, 16'h0003);
		chk("top_clr", 1'b0, top_status);
		wr(8'h12, 16'h000e);
		wr(8'h13, 16'h001e);
		repeat (7) sendf({16'h0101, 16'h0202});
		chk("forced_off", 1'b0, channel_online);
		chk("req_full", 1'b0, serial_data_request);
		clr();
		rd("full", 8'h16, 16'h0074);
		@(posedge clk);
		online_ctl <= 1'b0;
		pop(24);
		rd("flushed", 8'h16, 16'h0800, 16'h0800);
		rd("underflow", 8'h16, 16'h0008, 16'h0008);
		chk("top_under", 1'b1, top_status);
		rd("kept", 8'h16, 16'h0008, 16'h0008); // Read does not clear
		clr();
		rd("offline_live", 8'h16, 16'h0803);
		@(posedge clk);
		online_ctl <= 1'b1;
		clr();
		rd("online_live", 8'h16, 16'h0003);
		chk("online", 1'b1, channel_online);
		tx_enable <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk("req_off", 1'b0, serial_data_request);
		@(posedge clk);
		tx_enable <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk("req_on", 1'b1, serial_data_request);
		summarize();
	end
endmodule
